// ---- hw/charger_gauge_register_bank.sv ----
// Register bank of a charger gas gauge: watchdog, gauge, voltage monitor.
// Assumes converter strobes and data are on clk_sys_i; SCL, SDA and the
// reset pin are asynchronous and are synchronised before use.
//
// Overview of operation
// - Period field selects 1, 15, 30, 60 minutes.
// - Restart bit restarts watchdog, then clears itself.
// - Elapsed bit reads 1 after watchdog timeout.
// - Gauge disabled holds both accumulators cleared.
// - Clear-charge bit zeroes charge accumulator, self-clears.
// - Clear-discharge bit zeroes discharge accumulator, self-clears.
// - Clear-count bit zeroes conversion counter, self-clears.
// - Read request snapshots accumulators and counter together.
// - Calibrate bits put each converter into calibration.
// - Conversion-done flag sets, cleared by control read.
// - Monitor power bit enables the voltage ADC.
// - Ready bit reports voltage ADC ready state.
// - Start bit launches one conversion, reads zero.
// - Busy bit reads 1 during conversion.
// - Twelve-bit result splits low byte, high nibble.
// - Seven-bit result in low bits, bit7 zero.
// - Seven-bit mode high result reads zero.
// - Reset pin falling reloads all but accumulators and counter.
// - Register address byte; byte, word, block reads.
`timescale 1ns/1ps
`include "gauge_defines.svh"

module charger_gauge_register_bank #(
   parameter logic [6:0] DEV_ID = `I2C_DEV_ID,
   parameter int unsigned WD_TICK_CYCLES = `WD_TICK_CYCLES,
   parameter int unsigned WD_MS_PER_MIN = `WD_MS_PER_MIN
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic reset_pin_low_active_i,
   input wire logic gauge_eoc_i,
   input wire logic [12:0] gauge_data_i,
   input wire logic monitor_ready_i,
   input wire logic monitor_converting_i,
   input wire logic monitor_done_i,
   input wire logic [11:0] monitor_data_i,
   output logic gauge_enable_o,
   output logic gauge_calibrate_o,
   output logic monitor_power_on_o,
   output logic monitor_convert_start_o,
   output logic monitor_resolution_select_o,
   output logic monitor_calibrate_o,
   output logic timeout_elapsed_o
);
   regbus_if bus ();

   i2c_target #(
      .DEV_ID(DEV_ID)
   ) u_i2c (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(sda_oe_o),
      .bus(bus.ctl)
   );

   // Open-drain pin: only the enable ever changes
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Reset pin: two stages, then a third for the falling edge
   logic rpin_s1_q, rpin_s2_q, rpin_s3_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {rpin_s1_q, rpin_s2_q, rpin_s3_q} <= 3'h7;
      end else begin
         rpin_s1_q <= reset_pin_low_active_i;
         rpin_s2_q <= rpin_s1_q;
         rpin_s3_q <= rpin_s2_q;
      end
   end
   wire load_def_w = rpin_s3_q & ~rpin_s2_q;

   wire wr_wdog_w = bus.wr & hit(bus.addr, `OFS_WDOG);
   wire wr_gctrl_w = bus.wr & hit(bus.addr, `OFS_GCTRL);
   wire wr_vctrl_w = bus.wr & hit(bus.addr, `OFS_VCTRL);
   wire rd_gctrl_w = bus.rd & hit(bus.addr, `OFS_GCTRL);

   // Watchdog control; bits 3 and 6 of wdog_q are stored but never read back
   logic [7:0] wdog_q;
   logic wd_restart_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wdog_q <= `WDOG_RESET;
         wd_restart_q <= 1'b0;
      end else if (load_def_w) begin
         wdog_q <= `WDOG_RESET;
         wd_restart_q <= 1'b0;
      end else begin
         if (wr_wdog_w) begin
            wdog_q <= bus.wdata;
         end
         wd_restart_q <= wr_wdog_w & bus.wdata[`WD_RESTART];
      end
   end

   timeout_guard #(
      .TICK_CYCLES(WD_TICK_CYCLES),
      .MS_PER_MIN(WD_MS_PER_MIN)
   ) u_guard (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .enable_i(wdog_q[`WD_EN]),
      .period_sel_i(wdog_q[2:1]),
      .restart_i(wd_restart_q | load_def_w),
      .elapsed_o(timeout_elapsed_o)
   );

   wire [7:0] wdog_rd_w = {wdog_q[7], timeout_elapsed_o, wdog_q[5:4],
      wd_restart_q, wdog_q[2:0]};

   // Gauge control; gpend_q holds the self-clearing bits 4..1
   logic gen_q, gcal_q, gbit7_q, gdone_q;
   logic [3:0] gpend_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gen_q <= 1'b0;
         gcal_q <= 1'b0;
         gbit7_q <= 1'b0;
         gpend_q <= 4'h0;
      end else if (load_def_w) begin
         gen_q <= 1'b0;
         gcal_q <= 1'b0;
         gbit7_q <= 1'b0;
         gpend_q <= 4'h0;
      end else begin
         gpend_q <= wr_gctrl_w ? bus.wdata[4:1] : 4'h0;
         if (wr_gctrl_w) begin
            gen_q <= bus.wdata[`GC_EN];
            gbit7_q <= bus.wdata[7];
         end
         // Calibration ends with the converter's next end of conversion
         if (wr_gctrl_w && bus.wdata[`GC_CAL]) begin
            gcal_q <= 1'b1;
         end else if (gauge_eoc_i) begin
            gcal_q <= 1'b0;
         end
      end
   end

   // Set wins over the read that clears it
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gdone_q <= 1'b0;
      end else if (gauge_eoc_i && gen_q) begin
         gdone_q <= 1'b1;
      end else if (load_def_w || rd_gctrl_w) begin
         gdone_q <= 1'b0;
      end
   end

   assign gauge_enable_o = gen_q;
   assign gauge_calibrate_o = gcal_q;
   wire [7:0] gctrl_rd_w = {gbit7_q, gdone_q, gcal_q, gpend_q, gen_q};

   // Accumulators and counter see only the power-on reset
   logic [23:0] chg_acc_q, dis_acc_q;
   logic [11:0] cnt_q;
   wire neg_w = gauge_data_i[12];
   wire [12:0] mag_w = neg_w ? 13'(-gauge_data_i) : gauge_data_i;
   wire conv_w = gauge_eoc_i & gen_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         chg_acc_q <= 24'h0;
         dis_acc_q <= 24'h0;
         cnt_q <= 12'h0;
      end else begin
         if (!gen_q || gpend_q[0]) begin
            chg_acc_q <= 24'h0;
         end else if (conv_w && !neg_w) begin
            chg_acc_q <= chg_acc_q + 24'(mag_w);
         end
         if (!gen_q || gpend_q[1]) begin
            dis_acc_q <= 24'h0;
         end else if (conv_w && neg_w) begin
            dis_acc_q <= dis_acc_q + 24'(mag_w);
         end
         if (gpend_q[2]) begin
            cnt_q <= 12'h0;
         end else if (conv_w) begin
            cnt_q <= cnt_q + 12'h1;
         end
      end
   end

   // Snapshots and converter results
   logic [23:0] chg_snap_q, dis_snap_q;
   logic [11:0] cnt_snap_q;
   logic [12:0] gres_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         chg_snap_q <= 24'h0;
         dis_snap_q <= 24'h0;
         cnt_snap_q <= 12'h0;
         gres_q <= 13'h0;
      end else if (load_def_w) begin
         chg_snap_q <= 24'h0;
         dis_snap_q <= 24'h0;
         cnt_snap_q <= 12'h0;
         gres_q <= 13'h0;
      end else begin
         if (gpend_q[3]) begin
            chg_snap_q <= chg_acc_q;
            dis_snap_q <= dis_acc_q;
            cnt_snap_q <= cnt_q;
         end
         if (conv_w) begin
            gres_q <= gauge_data_i;
         end
      end
   end

   // Voltage monitor control and result
   logic vpwr_q, vres_q, vcal_q, vstart_q, vbit_unused_q;
   logic [7:0] vlo_q, vhi_q;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vpwr_q <= 1'b0;
         vres_q <= 1'b0;
         vcal_q <= 1'b0;
         vstart_q <= 1'b0;
      end else if (load_def_w) begin
         vpwr_q <= 1'b0;
         vres_q <= 1'b0;
         vcal_q <= 1'b0;
         vstart_q <= 1'b0;
      end else begin
         vstart_q <= wr_vctrl_w & bus.wdata[`VC_START];
         if (wr_vctrl_w) begin
            vpwr_q <= bus.wdata[`VC_PWR];
            vres_q <= bus.wdata[`VC_RES];
         end
         if (wr_vctrl_w && bus.wdata[`VC_CAL]) begin
            vcal_q <= 1'b1;
         end else if (monitor_done_i) begin
            vcal_q <= 1'b0;
         end
      end
   end

   // Seven-bit mode takes the converter's low seven bits
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vlo_q <= `DATA_RESET;
         vhi_q <= `DATA_RESET;
      end else if (load_def_w) begin
         vlo_q <= `DATA_RESET;
         vhi_q <= `DATA_RESET;
      end else if (monitor_done_i) begin
         vlo_q <= vres_q ? monitor_data_i[7:0] :
            {1'b0, monitor_data_i[6:0]};
         vhi_q <= vres_q ? {4'h0, monitor_data_i[11:8]} : 8'h00;
      end
   end

   assign monitor_power_on_o = vpwr_q;
   assign monitor_convert_start_o = vstart_q;
   assign monitor_resolution_select_o = vres_q;
   assign monitor_calibrate_o = vcal_q;
   // Start always reads zero; ready and busy come straight from the ADC
   wire [7:0] vctrl_rd_w = {2'h0, vcal_q, vres_q, monitor_converting_i,
      1'b0, monitor_ready_i, vpwr_q};

   // Read selection; unmapped offsets read zero. A process, not a
   // function in an assign, so it follows the registers as well as addr
   always_comb begin
      case (bus.addr)
         `OFS_WDOG: bus.rdata = wdog_rd_w;
         `OFS_GCTRL: bus.rdata = gctrl_rd_w;
         `OFS_CHG_LO: bus.rdata = chg_snap_q[7:0];
         `OFS_CHG_MID: bus.rdata = chg_snap_q[15:8];
         `OFS_CHG_HI: bus.rdata = chg_snap_q[23:16];
         `OFS_DIS_LO: bus.rdata = dis_snap_q[7:0];
         `OFS_DIS_MID: bus.rdata = dis_snap_q[15:8];
         `OFS_DIS_HI: bus.rdata = dis_snap_q[23:16];
         `OFS_GRES_LO: bus.rdata = gres_q[7:0];
         `OFS_GRES_HI: bus.rdata = {3'h0, gres_q[12:8]};
         `OFS_CNT_LO: bus.rdata = cnt_snap_q[7:0];
         `OFS_CNT_HI: bus.rdata = {4'h0, cnt_snap_q[11:8]};
         `OFS_VCTRL: bus.rdata = vctrl_rd_w;
         `OFS_VRES_LO: bus.rdata = vlo_q;
         `OFS_VRES_HI: bus.rdata = vhi_q;
         default: bus.rdata = 8'h00;
      endcase
   end

   // Checks
   wd_restart_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_wdog_w && bus.wdata[`WD_RESTART] && !load_def_w) |=>
      wd_restart_q ##1 (!wd_restart_q && !timeout_elapsed_o))
      else $error("watchdog restart bit did not act and clear");

   gauge_off_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !gen_q |=> (chg_acc_q == 24'h0) && (dis_acc_q == 24'h0))
      else $error("accumulators not held clear while gauge is off");

   chg_clear_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_gctrl_w && bus.wdata[1] && !load_def_w) |=> gpend_q[0]
      ##1 (chg_acc_q == 24'h0 && !gpend_q[0]))
      else $error("charge accumulator clear failed");

   snap_copy_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (gpend_q[3] && !load_def_w) |=> (chg_snap_q == $past(chg_acc_q)) &&
      (dis_snap_q == $past(dis_acc_q)) && (cnt_snap_q == $past(cnt_q)))
      else $error("snapshot does not match accumulators");

   snap_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (!gpend_q[3] && !load_def_w) |=> $stable(chg_snap_q))
      else $error("charge snapshot moved without a read request");

   done_flag_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      conv_w |=> gdone_q)
      else $error("conversion done flag not set");

   count_step_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (conv_w && !gpend_q[2]) |=> cnt_q == $past(cnt_q) + 12'h1)
      else $error("conversion counter did not step");

   start_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (wr_vctrl_w && bus.wdata[`VC_START] && !load_def_w) |=>
      monitor_convert_start_o ##1 !monitor_convert_start_o)
      else $error("start is not a single pulse");

   short_res_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (monitor_done_i && !vres_q && !load_def_w) |=>
      (vhi_q == 8'h00) && !vlo_q[7])
      else $error("seven-bit result layout wrong");

   power_bit_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(rpin_s2_q) |=> !monitor_power_on_o && !gauge_enable_o)
      else $error("reset pin did not reload control bits");
endmodule // charger_gauge_register_bank

// ---- hw/gauge_defines.svh ----
// Register offsets, field positions, reset values and timing counts
// of the charger gas gauge register bank. Definitions only.
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH

`define OFS_WDOG 8'h02
`define OFS_GCTRL 8'h03
`define OFS_CHG_LO 8'h04
`define OFS_CHG_MID 8'h05
`define OFS_CHG_HI 8'h06
`define OFS_DIS_LO 8'h07
`define OFS_DIS_MID 8'h08
`define OFS_DIS_HI 8'h09
`define OFS_GRES_LO 8'h10
`define OFS_GRES_HI 8'h11
`define OFS_CNT_LO 8'h12
`define OFS_CNT_HI 8'h13
`define OFS_VCTRL 8'h14
`define OFS_VRES_LO 8'h15
`define OFS_VRES_HI 8'h16

`define WDOG_RESET 8'h01
`define GCTRL_RESET 8'h00
`define VCTRL_RESET 8'h00
`define DATA_RESET 8'h00

`define WD_EN 0
`define WD_RESTART 3
`define GC_EN 0
`define GC_CAL 5
`define VC_PWR 0
`define VC_START 2
`define VC_RES 4
`define VC_CAL 5

`define I2C_DEV_ID 7'h70

`define CLK_HZ 100000000
`define WD_TICK_MS 1
`define WD_TICK_CYCLES (`CLK_HZ / 1000 * `WD_TICK_MS)
`define WD_MINUTE_S 60
`define WD_MS_PER_MIN (`WD_MINUTE_S * 1000 / `WD_TICK_MS)
`define WD_SEL0_MIN 1
`define WD_SEL1_MIN 15
`define WD_SEL2_MIN 30
`define WD_SEL3_MIN 60

`endif

// ---- hw/gauge_pkg.sv ----
// Types of the register bank's serial target; the bank itself uses none.
// Assumes nothing of its surroundings.
package gauge_pkg;
   typedef enum logic [3:0] {
      I2C_IDLE,
      I2C_DEV,
      I2C_REG,
      I2C_WR,
      I2C_DACK,
      I2C_RACK,
      I2C_WACK,
      I2C_RD,
      I2C_MACK,
      I2C_MLOAD
   } i2c_state_e;
endpackage

// ---- hw/regbus_if.sv ----
// Internal register access path between the serial target and the bank.
// Assumes both ends run on clk_sys_i.
`timescale 1ns/1ps
interface regbus_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   modport ctl (output addr, output wdata, output wr, output rd,
      input rdata);
   modport bank (input addr, input wdata, input wr, input rd,
      output rdata);
endinterface

// ---- hw/i2c_target.sv ----
// Serial two-wire target: device address, register address, data.
// Assumes SCL and SDA are asynchronous; both pass two flip-flops here.
`timescale 1ns/1ps
`include "gauge_defines.svh"

module i2c_target #(
   parameter logic [6:0] DEV_ID = `I2C_DEV_ID
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   regbus_if.ctl bus
);
   gauge_pkg::i2c_state_e st_q;
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;
   logic [7:0] sh_q;
   logic [7:0] addr_q;
   logic [3:0] cnt_q;
   logic rw_q, wr_q, rd_q;

   wire rise_w = scl_s2_q & ~scl_s3_q;
   wire fall_w = ~scl_s2_q & scl_s3_q;
   wire start_w = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   wire stop_w = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
   wire byte_w = fall_w & (cnt_q == 4'h8);
   wire load_w = fall_w & ((st_q == gauge_pkg::I2C_MLOAD) |
      ((st_q == gauge_pkg::I2C_DACK) & rw_q));

   assign bus.addr = addr_q;
   assign bus.wdata = sh_q;
   assign bus.wr = wr_q;
   assign bus.rd = rd_q;

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      end else begin
         {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
      end
   end

   // Data changes only after SCL falls, so the master sees it settled
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= gauge_pkg::I2C_IDLE;
         sda_oe_o <= 1'b0;
         sh_q <= 8'h00;
         addr_q <= 8'h00;
         cnt_q <= 4'h0;
         rw_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         rd_q <= load_w;
         if (stop_w) begin
            st_q <= gauge_pkg::I2C_IDLE;
            sda_oe_o <= 1'b0;
         end else if (start_w) begin
            st_q <= gauge_pkg::I2C_DEV;
            cnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
         end else if (load_w) begin
            sh_q <= bus.rdata;
            sda_oe_o <= ~bus.rdata[7];
            cnt_q <= 4'h1;
            st_q <= gauge_pkg::I2C_RD;
         end else begin
            case (st_q)
               gauge_pkg::I2C_DEV, gauge_pkg::I2C_REG,
               gauge_pkg::I2C_WR: begin
                  if (rise_w) begin
                     sh_q <= {sh_q[6:0], sda_s2_q};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (byte_w) begin
                     cnt_q <= 4'h0;
                     if (st_q == gauge_pkg::I2C_REG) begin
                        addr_q <= sh_q;
                        sda_oe_o <= 1'b1;
                        st_q <= gauge_pkg::I2C_RACK;
                     end else if (st_q == gauge_pkg::I2C_WR) begin
                        wr_q <= 1'b1;
                        sda_oe_o <= 1'b1;
                        st_q <= gauge_pkg::I2C_WACK;
                     end else if (sh_q[7:1] == DEV_ID) begin
                        rw_q <= sh_q[0];
                        sda_oe_o <= 1'b1;
                        st_q <= gauge_pkg::I2C_DACK;
                     end else begin
                        st_q <= gauge_pkg::I2C_IDLE;
                     end
                  end
               end
               gauge_pkg::I2C_DACK, gauge_pkg::I2C_RACK: begin
                  if (fall_w) begin
                     sda_oe_o <= 1'b0;
                     cnt_q <= 4'h0;
                     st_q <= (st_q == gauge_pkg::I2C_DACK) ?
                        gauge_pkg::I2C_REG : gauge_pkg::I2C_WR;
                  end
               end
               // One data byte per write; later bytes go unacknowledged
               gauge_pkg::I2C_WACK: begin
                  if (fall_w) begin
                     sda_oe_o <= 1'b0;
                     st_q <= gauge_pkg::I2C_IDLE;
                  end
               end
               gauge_pkg::I2C_RD: begin
                  if (fall_w) begin
                     if (cnt_q == 4'h8) begin
                        sda_oe_o <= 1'b0;
                        st_q <= gauge_pkg::I2C_MACK;
                     end else begin
                        sda_oe_o <= ~sh_q[6];
                        sh_q <= {sh_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                     end
                  end
               end
               gauge_pkg::I2C_MACK: begin
                  if (rise_w) begin
                     if (!sda_s2_q) begin
                        addr_q <= addr_q + 8'h01;
                        st_q <= gauge_pkg::I2C_MLOAD;
                     end else begin
                        st_q <= gauge_pkg::I2C_IDLE;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end
endmodule // i2c_target

// ---- hw/timeout_guard.sv ----
// Watchdog security timer with a millisecond prescaler.
// Assumes restart_i is a one-cycle pulse on clk_sys_i.
`timescale 1ns/1ps
`include "gauge_defines.svh"

module timeout_guard #(
   parameter int unsigned TICK_CYCLES = `WD_TICK_CYCLES,
   parameter int unsigned MS_PER_MIN = `WD_MS_PER_MIN
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic enable_i,
   input wire logic [1:0] period_sel_i,
   input wire logic restart_i,
   output logic elapsed_o
);
   localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
   logic [PW-1:0] pre_q;
   logic [21:0] ms_q;

   function automatic logic [21:0] limit_of(input logic [1:0] sel);
      case (sel)
         2'h0: limit_of = 22'(`WD_SEL0_MIN * MS_PER_MIN);
         2'h1: limit_of = 22'(`WD_SEL1_MIN * MS_PER_MIN);
         2'h2: limit_of = 22'(`WD_SEL2_MIN * MS_PER_MIN);
         default: limit_of = 22'(`WD_SEL3_MIN * MS_PER_MIN);
      endcase
   endfunction

   wire tick_w = (pre_q == PW'(TICK_CYCLES - 1));
   wire [21:0] limit_w = limit_of(period_sel_i);

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_q <= '0;
         ms_q <= 22'h0;
         elapsed_o <= 1'b0;
      end else if (restart_i || !enable_i) begin
         pre_q <= '0;
         ms_q <= 22'h0;
         elapsed_o <= 1'b0;
      end else begin
         pre_q <= tick_w ? '0 : pre_q + PW'(1);
         if (tick_w && !elapsed_o) begin
            ms_q <= ms_q + 22'h1;
            elapsed_o <= (ms_q + 22'h1 >= limit_w);
         end
      end
   end

   wd_period_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(elapsed_o) |-> $past(ms_q) + 22'h1 >= $past(limit_w))
      else $error("watchdog elapsed before its period");
endmodule // timeout_guard

// ---- sim/i2c_master_model.sv ----
// Two-wire bus master model: start, stop, byte transfers, register access.
// Assumes the bench resolves SDA from all drivers with a pull-up.
`timescale 1ns/1ps
module i2c_master_model (
   output logic scl_o,
   output logic sda_o,
   input wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic start();
      sda_o = 1'b1;
      #40 scl_o = 1'b1;
      #80 sda_o = 1'b0;
      #80 scl_o = 1'b0;
   endtask
   task automatic stop();
      #40 sda_o = 1'b0;
      #40 scl_o = 1'b1;
      #80 sda_o = 1'b1;
      #80;
   endtask
   // Eight data bits then the acknowledge slot, 160 ns a bit
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         #40 sda_o = tx[i];
         #40 scl_o = 1'b1;
         #40 rx[i] = sda_i;
         #40 scl_o = 1'b0;
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      logic [8:0] r;
      start();
      xfer({8'hE0, 1'b1}, r);
      xfer({a, 1'b1}, r);
      xfer({d, 1'b1}, r);
      stop();
   endtask
   // Single byte read, ended by a master not-acknowledge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] r;
      start();
      xfer({8'hE0, 1'b1}, r);
      xfer({a, 1'b1}, r);
      start();
      xfer({8'hE1, 1'b1}, r);
      xfer({8'hFF, 1'b1}, r);
      d = r[8:1];
      stop();
   endtask
   // Two-byte block read: the first byte is acknowledged by the master
   task automatic rd_pair(input logic [7:0] a, output logic [15:0] d);
      logic [8:0] r;
      start();
      xfer({8'hE0, 1'b1}, r);
      xfer({a, 1'b1}, r);
      start();
      xfer({8'hE1, 1'b1}, r);
      xfer({8'hFF, 1'b0}, r);
      d[7:0] = r[8:1];
      xfer({8'hFF, 1'b1}, r);
      d[15:8] = r[8:1];
      stop();
   endtask
endmodule // i2c_master_model

// ---- sim/charger_gauge_register_bank_tb.sv ----
// Self-checking bench of the charger gauge register bank.
// Assumes the master model drives SCL; SDA has a pull-up.
`timescale 1ns/1ps
module charger_gauge_register_bank_tb;
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, reset_pin_low_active_i = 1'b1;
   logic gauge_eoc_i = 1'b0, monitor_ready_i = 1'b0;
   logic monitor_converting_i = 1'b0, monitor_done_i = 1'b0;
   logic [12:0] gauge_data_i = 13'h0000;
   logic [11:0] monitor_data_i = 12'h000;
   wire scl_i, m_sda, sda_o, sda_oe_o, gauge_enable_o, gauge_calibrate_o;
   wire monitor_power_on_o, monitor_convert_start_o, timeout_elapsed_o;
   wire monitor_resolution_select_o, monitor_calibrate_o;
   wire sda_i = m_sda & ~sda_oe_o;
   int fail_count = 0, check_count = 0, start_seen = 0;
   charger_gauge_register_bank #(.WD_TICK_CYCLES(10), .WD_MS_PER_MIN(5))
      dut (.*);
   i2c_master_model m (.scl_o(scl_i), .sda_o(m_sda), .sda_i(sda_i));
   initial forever #5 clk_sys_i = ~clk_sys_i;
   // Start is a one-cycle pulse, so exactly one falling edge sees it
   always @(negedge clk_sys_i) begin
      if (monitor_convert_start_o === 1'b1)
         start_seen++;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      m.rd_reg(a, d);
      chk(d, exp);
   endtask
   task automatic gpulse(input logic [12:0] v);
      @(negedge clk_sys_i) gauge_data_i = v;
      gauge_eoc_i = 1'b1;
      @(negedge clk_sys_i) gauge_eoc_i = 1'b0;
   endtask
   task automatic vpulse(input logic [11:0] v);
      @(negedge clk_sys_i) monitor_data_i = v;
      monitor_done_i = 1'b1;
      @(negedge clk_sys_i) monitor_done_i = 1'b0;
   endtask
   task automatic t_wdog();
      rd(8'h02, 8'h41);
      m.wr_reg(8'h02, 8'h0F);
      rd(8'h02, 8'h07);
      chk({7'h00, timeout_elapsed_o}, 8'h00);
      repeat (2600) @(negedge clk_sys_i);
      chk({7'h00, timeout_elapsed_o}, 8'h01);
      $display("test watchdog done");
   endtask
   task automatic t_gauge();
      logic [15:0] w;
      rd(8'h03, 8'h00);
      m.wr_reg(8'h03, 8'h01);
      chk({7'h00, gauge_enable_o}, 8'h01);
      gpulse(13'h0005);
      gpulse(13'h0005);
      gpulse(13'h1FFD);
      rd(8'h03, 8'h41);
      rd(8'h03, 8'h01);
      m.wr_reg(8'h03, 8'h11);
      rd(8'h04, 8'h0A);
      rd(8'h07, 8'h03);
      rd(8'h12, 8'h03);
      m.rd_pair(8'h10, w);
      chk(w[7:0], 8'hFD);
      chk(w[15:8], 8'h1F);
      m.wr_reg(8'h03, 8'h2F);
      chk({7'h00, gauge_calibrate_o}, 8'h01);
      m.wr_reg(8'h03, 8'h11);
      rd(8'h04, 8'h00);
      rd(8'h07, 8'h00);
      rd(8'h12, 8'h00);
      $display("test gauge done");
   endtask
   task automatic t_volt();
      rd(8'h14, 8'h00);
      m.wr_reg(8'h14, 8'h35);
      chk({4'h0, sda_o, monitor_calibrate_o, monitor_resolution_select_o,
         monitor_power_on_o}, 8'h07);
      chk(8'(start_seen), 8'h01);
      rd(8'h14, 8'h31);
      vpulse(12'hABC);
      rd(8'h15, 8'hBC);
      rd(8'h16, 8'h0A);
      m.wr_reg(8'h14, 8'h01);
      vpulse(12'hABC);
      rd(8'h15, 8'h3C);
      rd(8'h16, 8'h00);
      @(negedge clk_sys_i) monitor_ready_i = 1'b1;
      monitor_converting_i = 1'b1;
      rd(8'h14, 8'h0B);
      $display("test monitor done");
   endtask
   task automatic t_pin();
      @(negedge clk_sys_i) reset_pin_low_active_i = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      reset_pin_low_active_i = 1'b1;
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h14, 8'h0A);
      $display("test reset pin done");
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      t_wdog();
      t_gauge();
      t_volt();
      t_pin();
      give_verdict();
   end
   // About 30 transfers of 6 us each plus the watchdog wait
   initial begin
      #500us;
      fail_count++;
      give_verdict();
   end
endmodule // charger_gauge_register_bank_tb
